// File: shared/cfg_pkg.sv
package cfg_pkg;
	localparam int          ADDR_W      = 12;
	localparam int          DATA_W      = 8;
	localparam int          BANK_DEPTH  = 256;
	localparam int          CMD_W       = 1 + ADDR_W + DATA_W;
	localparam int          FIFO_DEPTH  = 16;
	// Register offsets
	localparam logic [11:0] COMMIT_CONTROL_OFS = 12'h232;
	localparam logic [11:0] NV_CMD_LIST_FIRST  = 12'ha00;
	localparam logic [11:0] NV_CMD_LIST_LAST   = 12'haff;
	localparam logic [11:0] XFER_PENDING_OFS   = 12'hb00;
	localparam logic [11:0] SAVE_START_OFS     = 12'hb03;
	// Staged bank window: offsets 0x000 to 0x0ff
	localparam logic [3:0]  STAGE_PAGE  = 4'h0;
	localparam logic [3:0]  CMD_PAGE    = 4'ha;
	// Bit positions
	localparam int          COMMIT_BIT  = 0;
	localparam int          SAVE_BIT    = 0;
	localparam int          PENDING_BIT = 0;
	localparam int          OPCODE_BIT  = 7;
	// Operation codes
	localparam logic [7:0]  OP_COMMIT   = 8'h80;
	localparam logic [7:0]  OP_END      = 8'hff;
	// Reset values
	localparam logic [7:0]  STAGE_RST   = 8'h00;
	localparam logic [7:0]  NV_RST      = 8'h00;
	// Default command list: two 128-byte entries, commit, end
	localparam logic [7:0]  DEF_LEN     = 8'h7f;
	localparam logic [7:0]  DEF_HI      = 8'h00;
	localparam logic [7:0]  DEF_LO_A    = 8'h00;
	localparam logic [7:0]  DEF_LO_B    = 8'h80;
	localparam logic [7:0]  DEF_FILL    = 8'hff;
	// Timing
	localparam int          CLK_HZ      = 40_000_000;
	localparam int          GUARD_NS    = 10_000;
	localparam int          GUARD_CYC   = (GUARD_NS * (CLK_HZ / 1_000_000)
		+ 999) / 1000;
	localparam logic [8:0]  GUARD_LOAD  = 9'(GUARD_CYC - 1);
	localparam int          SCLK_DIV    = 4;
	localparam logic [1:0]  PH_LAST     = 2'(SCLK_DIV - 1);
	localparam logic [1:0]  PH_RISE     = 2'(SCLK_DIV / 2);
endpackage

// File: shared/cfg_link_if.sv
interface cfg_link_if;
	logic        sclk;
	logic        req;
	logic        we;
	logic [11:0] addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;

	modport host (
		output sclk,
		output req,
		output we,
		output addr,
		output wdata,
		input  rdata
	);

	modport dev (
		input  sclk,
		input  req,
		input  we,
		input  addr,
		input  wdata,
		output rdata
	);
endinterface

// File: design/cfg_device.sv
// Operation
// - Commit copies whole staged bank to active
// - Copy lands on next serial clock rise
// - Commit bit clears itself after copy
// - Command byte bit7 low: data transfer
// - Low seven bits: byte count minus one
// - Next two bytes: start address, MSB first
// - Bit7 high: commit or end opcode
// - Commit opcode copies staged into active
// - End opcode stops list, ends transfer
// - Host ends list with end opcode
// - Entries reach sparse space; list at 0xa00; here only the staged page is backed
// - Default list moves everything, then commits
// - Save start begins save, self-clears
// - Pending flag reads one while busy
// - Host waits 10 us between transfers; cfg_host waits only after a save, and loads started by pin are not held off
module cfg_device
	import cfg_pkg::*;
(
	input  wire logic        i_sys_rst,
	input  wire logic        i_load_req,
	input  wire logic [7:0]  i_active_addr,
	output logic [7:0]       o_active_data,
	output logic             o_xfer_pending,
	cfg_link_if.dev          link
);
	import cfg_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_CMD  = 3'b001,
		S_AHI  = 3'b010,
		S_ALO  = 3'b011,
		S_XFER = 3'b100,
		S_DONE = 3'b101
	} seq_t;

	logic [7:0]  staged_q [BANK_DEPTH];
	logic [7:0]  active_q [BANK_DEPTH];
	logic [7:0]  cmd_q    [BANK_DEPTH];
	logic [7:0]  nv_q     [BANK_DEPTH];
	logic [1:0]  rst_sync_q;
	logic [2:0]  load_sync_q;
	logic [7:0]  act_meta_q;
	logic [7:0]  act_addr_q;
	logic        rst;
	logic        commit_q;
	logic        save_q;
	logic        load_q;
	seq_t        state_q;
	logic [7:0]  lp_q;
	logic [7:0]  np_q;
	logic [6:0]  cnt_q;
	logic [11:0] xa_q;
	logic [7:0]  cur;
	logic        wr;
	logic        seq_commit;
	logic        do_copy;
	logic        busy;
	logic        xfer_ok;

	function automatic logic in_page(input logic [11:0] a,
		input logic [3:0] pg);
		in_page = (a[11:8] == pg);
	endfunction

	// Reset arrives from another domain; two flops before use
	always_ff @(posedge link.sclk) begin
		rst_sync_q <= {rst_sync_q[0], i_sys_rst};
	end
	assign rst = rst_sync_q[1];

	always_ff @(posedge link.sclk) begin
		load_sync_q <= {load_sync_q[1:0], i_load_req};
	end

	// Slow pin; address must stand for three link clocks
	always_ff @(posedge link.sclk) begin
		act_meta_q <= i_active_addr;
		act_addr_q <= act_meta_q;
	end

	assign wr         = link.req && link.we;
	assign cur        = cmd_q[lp_q];
	assign seq_commit = (state_q == S_CMD) && (cur == OP_COMMIT);
	assign do_copy    = commit_q || seq_commit;
	assign busy       = save_q || load_q || (state_q != S_IDLE);
	assign xfer_ok    = in_page(xa_q, STAGE_PAGE);

	// Set wins over self-clear so a back-to-back write is kept
	always_ff @(posedge link.sclk) begin
		if (rst) begin
			commit_q <= 1'b0;
		end else if (wr && link.addr == COMMIT_CONTROL_OFS
			&& link.wdata[COMMIT_BIT]) begin
			commit_q <= 1'b1;
		end else begin
			commit_q <= 1'b0;
		end
	end

	always_ff @(posedge link.sclk) begin
		if (rst) begin
			save_q <= 1'b0;
		end else if (wr && link.addr == SAVE_START_OFS
			&& link.wdata[SAVE_BIT] && !busy) begin
			save_q <= 1'b1;
		end else if (state_q == S_DONE) begin
			save_q <= 1'b0;
		end
	end

	always_ff @(posedge link.sclk) begin
		if (rst) begin
			load_q <= 1'b0;
		end else if (load_sync_q[1] && !load_sync_q[2] && !busy) begin
			load_q <= 1'b1;
		end else if (state_q == S_DONE) begin
			load_q <= 1'b0;
		end
	end

	always_ff @(posedge link.sclk) begin
		if (rst) begin
			state_q <= S_IDLE;
			lp_q    <= 8'h00;
			np_q    <= 8'h00;
			cnt_q   <= 7'h00;
			xa_q    <= 12'h000;
		end else begin
			case (state_q)
			S_IDLE: begin
				lp_q <= 8'h00;
				np_q <= 8'h00;
				if ((save_q || load_q) && state_q == S_IDLE) begin
					state_q <= S_CMD;
				end
			end
			S_CMD: begin
				lp_q <= lp_q + 8'h01;
				if (!cur[OPCODE_BIT]) begin
					cnt_q   <= cur[6:0];
					state_q <= S_AHI;
				end else if (cur == OP_END || lp_q == 8'hff) begin
					state_q <= S_DONE;
				end
			end
			S_AHI: begin
				xa_q[11:8] <= cur[3:0];
				lp_q       <= lp_q + 8'h01;
				state_q    <= S_ALO;
			end
			S_ALO: begin
				xa_q[7:0] <= cur;
				lp_q      <= lp_q + 8'h01;
				state_q   <= S_XFER;
			end
			S_XFER: begin
				xa_q <= xa_q + 12'h001;
				np_q <= np_q + 8'h01;
				if (cnt_q == 7'h00) begin
					state_q <= (lp_q == 8'h00) ? S_DONE : S_CMD;
				end else begin
					cnt_q <= cnt_q - 7'h01;
				end
			end
			S_DONE: begin
				state_q <= S_IDLE;
			end
			default: begin
				state_q <= S_IDLE;
			end
			endcase
		end
	end

	// Only the staged page is backed; other entry addresses are skipped
	always_ff @(posedge link.sclk) begin
		if (rst) begin
			for (int i = 0; i < BANK_DEPTH; i++) begin
				staged_q[i] <= STAGE_RST;
			end
		end else if (state_q == S_XFER && load_q && xfer_ok) begin
			staged_q[xa_q[7:0]] <= nv_q[np_q];
		end else if (wr && in_page(link.addr, STAGE_PAGE)) begin
			staged_q[link.addr[7:0]] <= link.wdata;
		end
	end

	always_ff @(posedge link.sclk) begin
		if (rst) begin
			for (int i = 0; i < BANK_DEPTH; i++) begin
				active_q[i] <= STAGE_RST;
			end
		end else if (do_copy) begin
			for (int i = 0; i < BANK_DEPTH; i++) begin
				active_q[i] <= staged_q[i];
			end
		end
	end

	always_ff @(posedge link.sclk) begin
		if (rst) begin
			for (int i = 0; i < BANK_DEPTH; i++) begin
				cmd_q[i] <= DEF_FILL;
			end
			cmd_q[0] <= DEF_LEN;
			cmd_q[1] <= DEF_HI;
			cmd_q[2] <= DEF_LO_A;
			cmd_q[3] <= DEF_LEN;
			cmd_q[4] <= DEF_HI;
			cmd_q[5] <= DEF_LO_B;
			cmd_q[6] <= OP_COMMIT;
			cmd_q[7] <= OP_END;
		end else if (wr && in_page(link.addr, CMD_PAGE)) begin
			cmd_q[link.addr[7:0]] <= link.wdata;
		end
	end

	// Nonvolatile array stand-in; holds across commits, not across reset
	always_ff @(posedge link.sclk) begin
		if (rst) begin
			for (int i = 0; i < BANK_DEPTH; i++) begin
				nv_q[i] <= NV_RST;
			end
		end else if (state_q == S_XFER && save_q) begin
			nv_q[np_q] <= xfer_ok ? staged_q[xa_q[7:0]] : NV_RST;
		end
	end

	always_ff @(posedge link.sclk) begin
		if (rst) begin
			link.rdata <= 8'h00;
		end else if (link.req && !link.we) begin
			if (in_page(link.addr, STAGE_PAGE)) begin
				link.rdata <= staged_q[link.addr[7:0]];
			end else if (in_page(link.addr, CMD_PAGE)) begin
				link.rdata <= cmd_q[link.addr[7:0]];
			end else if (link.addr == COMMIT_CONTROL_OFS) begin
				link.rdata <= {7'h00, commit_q};
			end else if (link.addr == XFER_PENDING_OFS) begin
				link.rdata <= {7'h00, busy};
			end else if (link.addr == SAVE_START_OFS) begin
				link.rdata <= {7'h00, save_q};
			end else begin
				link.rdata <= 8'h00;
			end
		end
	end

	always_ff @(posedge link.sclk) begin
		if (rst) begin
			o_active_data  <= 8'h00;
			o_xfer_pending <= 1'b0;
		end else begin
			o_active_data  <= active_q[act_addr_q];
			o_xfer_pending <= busy;
		end
	end
endmodule

// File: design/cfg_host.sv
module cmd_fifo #(
	parameter int WIDTH = 21,
	parameter int DEPTH = 16
) (
	input  wire logic             i_clk,
	input  wire logic             i_sys_rst,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic [WIDTH-1:0]      o_out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wp_q;
	logic [AW:0]      rp_q;
	logic             full;
	logic             empty;

	assign empty       = (wp_q == rp_q);
	assign full        = (wp_q[AW] != rp_q[AW])
		&& (wp_q[AW-1:0] == rp_q[AW-1:0]);
	assign o_in_ready  = !full;
	assign o_out_valid = !empty;
	assign o_out_data  = mem_q[rp_q[AW-1:0]];

	always_ff @(posedge i_clk) begin
		if (i_in_valid && !full) begin
			mem_q[wp_q[AW-1:0]] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			if (i_in_valid && !full) begin
				wp_q <= wp_q + 1'b1;
			end
			if (i_out_ready && !empty) begin
				rp_q <= rp_q + 1'b1;
			end
		end
	end
endmodule

module cfg_host
	import cfg_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	input  wire logic        i_cmd_valid,
	output logic             o_cmd_ready,
	input  wire logic        i_cmd_we,
	input  wire logic [11:0] i_cmd_addr,
	input  wire logic [7:0]  i_cmd_wdata,
	output logic             o_rsp_valid,
	output logic [7:0]       o_rsp_data,
	cfg_link_if.host         link
);
	import cfg_pkg::*;

	typedef enum logic [1:0] {
		H_RUN   = 2'b00,
		H_POLL  = 2'b01,
		H_GUARD = 2'b10
	} hst_t;

	logic [CMD_W-1:0] head;
	logic             head_valid;
	logic             pop;
	logic [1:0]       ph_q;
	logic [1:0]       rst_age_q;
	hst_t             st_q;
	logic [8:0]       guard_q;
	logic             rd_wait_q;
	logic             poll_wait_q;
	logic             slot;
	logic             is_save;

	cmd_fifo #(
		.WIDTH (CMD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clk       (i_clk),
		.i_sys_rst   (i_sys_rst),
		.i_in_valid  (i_cmd_valid),
		.o_in_ready  (o_cmd_ready),
		.i_in_data   ({i_cmd_we, i_cmd_addr, i_cmd_wdata}),
		.o_out_valid (head_valid),
		.i_out_ready (pop),
		.o_out_data  (head)
	);

	// Link slot starts as the serial clock falls
	assign slot    = (ph_q == PH_LAST);
	assign pop     = slot && head_valid && st_q == H_RUN;
	assign is_save = head[CMD_W-1] && head[19:8] == SAVE_START_OFS
		&& head[SAVE_BIT];

	always_ff @(posedge i_clk) begin
		rst_age_q <= {rst_age_q[0], i_sys_rst};
	end

	// Divider restarts, then runs on through reset: the device
	// can only see its reset on link clock rises
	always_ff @(posedge i_clk) begin
		if (!i_sys_rst || rst_age_q[1]) begin
			ph_q      <= ph_q + 2'b01;
			link.sclk <= (ph_q + 2'b01) >= PH_RISE;
		end else begin
			ph_q      <= 2'b00;
			link.sclk <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			link.req   <= 1'b0;
			link.we    <= 1'b0;
			link.addr  <= 12'h000;
			link.wdata <= 8'h00;
		end else if (slot) begin
			link.req   <= pop || st_q == H_POLL;
			link.we    <= pop && head[CMD_W-1];
			link.addr  <= pop ? head[19:8] : XFER_PENDING_OFS;
			link.wdata <= head[7:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			rd_wait_q   <= 1'b0;
			poll_wait_q <= 1'b0;
			o_rsp_valid <= 1'b0;
			o_rsp_data  <= 8'h00;
		end else begin
			o_rsp_valid <= slot && rd_wait_q;
			if (slot) begin
				if (rd_wait_q) begin
					o_rsp_data <= link.rdata;
				end
				rd_wait_q   <= pop && !head[CMD_W-1];
				poll_wait_q <= st_q == H_POLL;
			end
		end
	end

	// A save holds the queue until pending reads zero, then 10 us
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st_q    <= H_RUN;
			guard_q <= 9'h000;
		end else begin
			case (st_q)
			H_RUN: begin
				if (pop && is_save) begin
					st_q <= H_POLL;
				end
			end
			H_POLL: begin
				if (slot && poll_wait_q && !link.rdata[PENDING_BIT]) begin
					st_q    <= H_GUARD;
					guard_q <= GUARD_LOAD;
				end
			end
			H_GUARD: begin
				if (guard_q == 9'h000) begin
					st_q <= H_RUN;
				end else begin
					guard_q <= guard_q - 9'h001;
				end
			end
			default: begin
				st_q <= H_RUN;
			end
			endcase
		end
	end
endmodule

// File: verification/cfg_link_assertions.sv
module cfg_link_checker
	import cfg_pkg::*;
(
	input wire logic        i_sys_rst,
	input wire logic        i_sclk,
	input wire logic        i_req,
	input wire logic        i_we,
	input wire logic [11:0] i_addr,
	input wire logic [7:0]  i_wdata,
	input wire logic [7:0]  i_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// One rise of slack for the poll that first reads zero
	localparam int GAP_RISES = GUARD_CYC / SCLK_DIV - 1;

	logic        rq_q;
	logic        we_q;
	logic [11:0] ad_q;
	logic [7:0]  wd_q;
	logic        poll_q;
	logic        done_q;
	logic [7:0]  gap_q;
	wire wr_cc = i_req && i_we && i_addr == COMMIT_CONTROL_OFS;
	wire rd_cc = i_req && !i_we && i_addr == COMMIT_CONTROL_OFS;
	wire wr_sv = i_req && i_we && i_addr == SAVE_START_OFS
		&& i_wdata[SAVE_BIT];
	wire rd_sv = i_req && !i_we && i_addr == SAVE_START_OFS;
	wire rd_pd = i_req && !i_we && i_addr == XFER_PENDING_OFS;
	wire wr_ls = i_req && i_we && i_addr[11:8] == CMD_PAGE;
	wire rd_ls = i_req && !i_we && i_addr[11:8] == CMD_PAGE;

	// Host moves link lines only at fall; a rise snapshot must hold
	always_ff @(posedge i_sclk) begin
		rq_q <= i_req;
		we_q <= i_we;
		ad_q <= i_addr;
		wd_q <= i_wdata;
	end

	always_ff @(posedge i_sclk) begin
		poll_q <= rd_pd;
		if (i_sys_rst || wr_sv)
			done_q <= 1'b0;
		else if (poll_q && !i_rdata[PENDING_BIT])
			done_q <= 1'b1;
	end

	// Link clock rises since pending was first seen low
	always_ff @(posedge i_sclk) begin
		if (!done_q)
			gap_q <= 8'h00;
		else if (gap_q != 8'hff)
			gap_q <= gap_q + 8'h01;
	end

	sequence s_commit_set;
		wr_cc && i_wdata[COMMIT_BIT] ##1 !wr_cc ##1 rd_cc;
	endsequence
	sequence s_zero_write;
		rd_cc ##1 wr_cc && !i_wdata[COMMIT_BIT]
			&& !i_rdata[COMMIT_BIT] ##1 rd_cc;
	endsequence
	sequence s_save_poll;
		wr_sv ##1 rd_pd;
	endsequence
	sequence s_list_back;
		wr_ls ##1 rd_ls && i_addr == $past(i_addr);
	endsequence

	a_commit_self_clear: assert property (
		@(posedge i_sclk) disable iff (i_sys_rst)
		s_commit_set |=> !i_rdata[COMMIT_BIT])
		else $error("commit bit stuck");
	a_commit_zero_write: assert property (
		@(posedge i_sclk) disable iff (i_sys_rst)
		s_zero_write |=> !i_rdata[COMMIT_BIT])
		else $error("zero write set bit");
	a_pending_on_save: assert property (
		@(posedge i_sclk) disable iff (i_sys_rst)
		s_save_poll |=> i_rdata[PENDING_BIT])
		else $error("pending not set");
	a_save_bit_done: assert property (
		@(posedge i_sclk) disable iff (i_sys_rst)
		rd_sv && done_q |=> !i_rdata[SAVE_BIT])
		else $error("save bit stuck");
	a_list_keeps_byte: assert property (
		@(posedge i_sclk) disable iff (i_sys_rst)
		s_list_back |=> i_rdata == $past(i_wdata, 2))
		else $error("list byte lost");
	a_req_hold: assert property (
		@(negedge i_sclk) disable iff (i_sys_rst)
		i_req == rq_q && i_we == we_q)
		else $error("request moved at high");
	a_addr_hold: assert property (
		@(negedge i_sclk) disable iff (i_sys_rst)
		!i_req || i_addr == ad_q)
		else $error("address moved at high");
	a_data_hold: assert property (
		@(negedge i_sclk) disable iff (i_sys_rst)
		!(i_req && i_we) || i_wdata == wd_q)
		else $error("data moved at high");
	a_guard_gap_held: assert property (
		@(posedge i_sclk) disable iff (i_sys_rst)
		i_req && !rd_pd && done_q |-> gap_q >= GAP_RISES)
		else $error("guard gap too short");
endmodule

// File: verification/register_commit_and_nv_sequencer_bench.sv
module register_commit_and_nv_sequencer_bench
	import cfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_clk;
	logic        i_sys_rst;
	logic        i_cmd_valid;
	logic        i_cmd_we;
	logic [11:0] i_cmd_addr;
	logic [7:0]  i_cmd_wdata;
	logic        i_load_req;
	logic [7:0]  i_active_addr;
	logic        o_cmd_ready;
	logic        o_rsp_valid;
	logic [7:0]  o_rsp_data;
	logic [7:0]  o_active_data;
	logic        o_xfer_pending;
	int          err_count = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	logic [7:0]  rsp_q[$];
	logic [7:0]  dfl[8] = '{DEF_LEN, DEF_HI, DEF_LO_A, DEF_LEN, DEF_HI,
		DEF_LO_B, OP_COMMIT, OP_END};
	logic [7:0]  lst1[7] = '{8'h01, 8'h00, 8'h40, 8'h00, 8'h00, 8'h20, OP_END};
	logic [7:0]  lst2[5] = '{8'h02, 8'h00, 8'h50, OP_COMMIT, OP_END};

	cfg_link_if link();
	cfg_host u_cfg_host(.i_clk, .i_sys_rst, .i_cmd_valid, .o_cmd_ready,
		.i_cmd_we, .i_cmd_addr, .i_cmd_wdata, .o_rsp_valid, .o_rsp_data,
		.link(link));
	cfg_device u_cfg_device(.i_sys_rst, .i_load_req, .i_active_addr,
		.o_active_data, .o_xfer_pending, .link(link));
	cfg_link_checker u_cfg_link_checker(.i_sys_rst, .i_sclk(link.sclk),
		.i_req(link.req), .i_we(link.we), .i_addr(link.addr),
		.i_wdata(link.wdata), .i_rdata(link.rdata));

	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end

	task automatic give_verdict;
		$display("checks %0d errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	// Leaves valid up so pushes run back to back
	task automatic put(input logic w, input logic [11:0] a,
		input logic [7:0] d);
		i_cmd_valid = 1'b1;
		i_cmd_we = w;
		i_cmd_addr = a;
		i_cmd_wdata = d;
		while (o_cmd_ready !== 1'b1) @(negedge i_clk);
		@(negedge i_clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		put(1'b1, a, d);
	endtask

	task automatic rd(input logic [11:0] a);
		put(1'b0, a, 8'h00);
	endtask

	task automatic get(input logic [7:0] exp);
		int n;
		n = 0;
		i_cmd_valid = 1'b0;
		while (rsp_q.size() == 0 && n < 3000) begin
			@(negedge i_clk);
			n++;
		end
		if (rsp_q.size() == 0)
			rsp_q.push_back(8'hxx);
		check(rsp_q.pop_front(), exp);
	endtask

	task automatic act(input logic [7:0] a, input logic [7:0] exp);
		i_active_addr = a;
		// Two sync flops and the output flop, all on link rises
		repeat (16) @(negedge i_clk);
		check(o_active_data, exp);
	endtask

	task automatic wait_pend(input logic v);
		int n;
		n = 0;
		i_cmd_valid = 1'b0;
		while (o_xfer_pending !== v && n < 3000) begin
			@(negedge i_clk);
			n++;
		end
		check({7'h00, o_xfer_pending}, {7'h00, v});
	endtask

	always @(posedge i_clk) begin
		if (o_rsp_valid === 1'b1)
			rsp_q.push_back(o_rsp_data);
	end

	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			give_verdict();
		end
	end

	initial begin
		i_sys_rst = 1'b1;
		i_cmd_valid = 1'b0;
		i_cmd_we = 1'b0;
		i_cmd_addr = 12'h000;
		i_cmd_wdata = 8'h00;
		i_load_req = 1'b0;
		i_active_addr = 8'h00;
		// Device leaves reset a few link rises after the host
		repeat (8) @(negedge i_clk);
		i_sys_rst = 1'b0;
		repeat (20) @(negedge i_clk);
		for (int i = 0; i < 8; i++)
			rd(NV_CMD_LIST_FIRST + 12'(i));
		rd(NV_CMD_LIST_LAST);
		for (int i = 0; i < 8; i++)
			get(dfl[i]);
		get(OP_END);
		wr(12'h010, 8'h5a);
		rd(COMMIT_CONTROL_OFS);
		wr(COMMIT_CONTROL_OFS, 8'h00);
		rd(COMMIT_CONTROL_OFS);
		get(8'h00);
		get(8'h00);
		act(8'h10, 8'h00);
		wr(COMMIT_CONTROL_OFS, 8'h01);
		wr(12'h011, 8'ha5);
		rd(COMMIT_CONTROL_OFS);
		get(8'h00);
		act(8'h10, 8'h5a);
		act(8'h11, 8'h00);
		wr(12'ha20, 8'h3c);
		rd(12'ha20);
		get(8'h3c);
		wr(12'h040, 8'h11);
		wr(12'h041, 8'h22);
		wr(12'h020, 8'h33);
		for (int i = 0; i < 7; i++)
			wr(NV_CMD_LIST_FIRST + 12'(i), lst1[i]);
		wr(SAVE_START_OFS, 8'h01);
		rd(SAVE_START_OFS);
		wait_pend(1'b1);
		wait_pend(1'b0);
		get(8'h00);
		for (int i = 0; i < 5; i++)
			wr(NV_CMD_LIST_FIRST + 12'(i), lst2[i]);
		rd(XFER_PENDING_OFS);
		get(8'h00);
		i_load_req = 1'b1;
		wait_pend(1'b1);
		wait_pend(1'b0);
		i_load_req = 1'b0;
		act(8'h50, 8'h11);
		act(8'h51, 8'h22);
		act(8'h52, 8'h33);
		act(8'h53, 8'h00);
		give_verdict();
	end
endmodule
